//--- fcs_cyc_if.sv
/*
 * Bus-cycle request channel between the sequencer and the pin engine.
 * Assumes both ends share one clock; req is a one-cycle pulse.
 */
`timescale 1ns/1ps
interface fcs_cyc_if;
   import fcs_pkg::*;
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DQ_W-1:0] wdata;
   logic [DQ_W-1:0] rdata;
   logic done;
   modport master (output req, wr, addr, wdata, input rdata, done);
   modport engine (input req, wr, addr, wdata, output rdata, done);
endinterface

//--- fcs_flash_model.sv
/* Flash partner: command decoder, status register, 16 blocks of 16 bytes.
   Assumes the host moves its pins only on rising edges of clk. */
`timescale 1ns/1ps
module fcs_flash_model #(
   parameter logic [7:0] MAKER = 8'h5C, // Arbitrary value
   parameter logic [7:0] PART = 8'h3E, // Arbitrary value
   parameter logic [15:0] LOCKS = 16'h0002,
   parameter int BUSY = 200
) (
   input wire logic clk,
   input wire logic [19:0] addr,
   input wire logic [7:0] din,
   input wire logic oe_b,
   input wire logic we_b,
   input wire logic ce_b,
   input wire logic vpp,
   input wire logic ovr,
   output logic [7:0] dout,
   output logic rdy
);
   logic [7:0] mem [16][16];
   logic [7:0] sr = 8'h00, lat = 8'h00, idv;
   logic [1:0] mode = 0, pend = 0;
   logic we_q = 1, rd_q = 0, ers = 0;
   int cnt = 0;
   wire [3:0] b = addr[19:16];
   wire rd = !ce_b && !oe_b;
   wire lock = LOCKS[b] && !ovr;
   assign rdy = cnt == 0 || sr[6] || sr[2];
   wire [7:0] srd = {rdy, sr[6:1], 1'b0};
   // Released bus shows the inverse of the last value, never a stale copy
   assign dout = rd ? lat : ~lat;
   initial foreach (mem[i, j]) mem[i][j] = 8'hFF;
   // Identifier locations
   always_comb case (addr[1:0])
      2'd0: idv = MAKER;
      2'd1: idv = PART;
      2'd2: idv = {7'h0, LOCKS[b]};
      default: idv = 8'h00;
   endcase
   // Data latched once per strobe fall; commands taken on write release
   always @(posedge clk) begin
      we_q <= we_b;
      rd_q <= rd;
      if (cnt > 0 && !sr[6] && !sr[2]) cnt <= cnt - 1;
      if (rd && !rd_q) lat <= mode == 2 ? srd : mode == 1 ? idv :
         mem[b][addr[3:0]];
      if (we_b && !we_q) begin
         mode <= 2;
         pend <= 0;
         if (pend == 1) begin
            if (din != 8'hD0) sr[5:4] <= 2'b11;
            else if (!vpp) sr <= sr | 8'h28;
            else if (lock) sr <= sr | 8'h22;
            else begin
               for (int i = 0; i < 16; i++) mem[b][i] <= 8'hFF;
               cnt <= BUSY;
               ers <= 1;
            end
         end else if (pend == 2) begin
            if (!vpp) sr <= sr | 8'h18;
            else if (lock) sr <= sr | 8'h12;
            else begin
               mem[b][addr[3:0]] <= mem[b][addr[3:0]] & din;
               cnt <= BUSY;
               ers <= 0;
            end
         end else case (din)
            8'hFF: mode <= 0;
            8'h90: mode <= 1;
            8'h50: if (!sr[6] && !sr[2]) sr <= sr & 8'h44;
            8'h20: pend <= 1;
            8'h40, 8'h10: pend <= 2;
            8'hB0: if (cnt > 0) sr[ers ? 6 : 2] <= 1;
            8'hD0: sr <= sr & 8'hBB;
            default: ;
         endcase
      end
   end
endmodule // fcs_flash_model

//--- fcs_host.sv
/*
 * Host-side controller for a byte-wide flash with a command interpreter.
 * Software orders operations through Wishbone registers; the sequencer
 * writes command cycles, reads identifier or status data and polls for
 * completion. Assumes flash pins are synchronous to CLK and that the
 * bench resolves the data bus from FL_DQ_OE.
 */
// Decided for this implementation: the Wishbone register port.
// Behaviour
// R1: Identifier command lets reads return maker, part and global protect codes.
// R2: Identifier read at block offset two gives that block's protect bit.
// R3: Identifier and status commands work at any supply or override level.
// R4: After status command every read returns status until a new command.
// R5: Status latches on enable fall; host raises strobes between status reads.
// R6: Error bits 5,4,3,1 accumulate until the clear-status command.
// R7: Clear-status code clears errors; ignored while erase or write suspended.
// R8: Erase is setup plus confirm, both addressed inside the target block.
// R9: After erase or write, reads give status; bit 7 and ready mark done.
// R10: Erase setup without proper confirm sets status bits 4 and 5.
// R11: Erase at supply lockout leaves block intact, sets bits 3 and 5.
// R12: Erase of protected block fails with bits 1 and 5 unless overridden.
// R13: Byte write is setup code then address and data write.
// R14: Write verify flags bit 4 only for ones that failed to clear.
// R15: Write at supply lockout leaves memory intact, sets bits 3 and 4.
// R16: Write to protected block fails with bits 1 and 4 unless overridden.
// R17: Erase suspend halts erase, sets bits 7 and 6, ready goes high.
// R18: In erase suspend, array reads and writes to other blocks allowed.
// R19: Erase resume clears bits 6,7; erase waits for suspended-time writes.
// R20: Write suspend sets bits 7 and 2, ready high; few commands valid.
// R21: Write resume continues write, clears bits 2 and 7, ready low.
// R22: Host holds supply and override levels steady while suspended.
// R23: Erase setup code is 20h, confirm code D0h.
// R24: Suspend code B0h, resume code D0h, address ignored.
// R25: Status-read code is 70h at any address.
// R26: Status bit 7 ready; 6..1 suspend, error and supply flags.
// R27: Identifier code 90h, read-array code FFh, single writes.
`timescale 1ns/1ps
module fcs_host (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [fcs_pkg::WB_AW-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [fcs_pkg::DQ_W-1:0] FL_DQ_I,
   output logic [fcs_pkg::DQ_W-1:0] FL_DQ_O,
   output logic FL_DQ_OE,
   output logic [fcs_pkg::ADDR_W-1:0] FL_ADDR,
   output logic FL_CE_B,
   output logic FL_OE_B,
   output logic FL_WE_B,
   input wire logic READY_BUSY_N,
   output logic RESET_POWERDOWN_N,
   output logic RP_OVERRIDE,
   output logic VPP_ENABLE
);
   import fcs_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   fcs_cyc_if cyc ();
   fcs_seq_state_t state_q;
   logic tick;
   logic [OP_W-1:0] op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DQ_W-1:0] wdata_q;
   logic [DQ_W-1:0] fstat_q;
   logic [DQ_W-1:0] rdata_q;
   logic suspended_q;
   logic req_q;
   logic cwr_q;
   logic [DQ_W-1:0] cdata_q;
   logic busy_cyc;

   // ************************************************************
   // Register bus decode
   // ************************************************************
   wire wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wb_wr = wb_hit & WB_WE_I;
   wire idle = (state_q == S_IDLE);
   wire wr_ctrl = wb_wr & (WB_ADR_I == OFF_CTRL) & WB_SEL_I[0];
   wire wr_addr = wb_wr & (WB_ADR_I == OFF_ADDR) & idle;
   wire wr_wdata = wb_wr & (WB_ADR_I == OFF_WDATA) & WB_SEL_I[0] & idle;
   // Supply and override pins freeze while an operation is held
   wire wr_pin = wb_wr & (WB_ADR_I == OFF_PINCTL) & WB_SEL_I[0]
      & idle & ~suspended_q; // see R22
   wire [OP_W-1:0] new_op = WB_DAT_I[OP_W-1:0];
   wire op_ok = (new_op <= OP_READ);
   // A suspend may cut into the wait of a running erase or byte write,
   // but only while no poll read is on the pins
   wire susp_ok = (state_q == S_POLL) & ~busy_cyc & ~req_q
      & ((op_q == OP_ERASE) | (op_q == OP_PROGRAM))
      & (new_op == OP_SUSPEND); // see R17 R20
   wire start = wr_ctrl & op_ok & (idle | susp_ok);
   wire [31:0] stat_word = {8'h00, rdata_q, fstat_q, 6'h00, suspended_q,
      ~idle};
   wire [31:0] rd_mux =
      (WB_ADR_I == OFF_CTRL) ? {28'h000_0000, op_q} :
      (WB_ADR_I == OFF_ADDR) ? {12'h000, addr_q} :
      (WB_ADR_I == OFF_WDATA) ? {24'h00_0000, wdata_q} :
      (WB_ADR_I == OFF_PINCTL) ? {29'h0000_0000, RESET_POWERDOWN_N,
         RP_OVERRIDE, VPP_ENABLE} :
      (WB_ADR_I == OFF_STAT) ? stat_word : 32'h0000_0000;

   // Bus answer: one-cycle ack, unmapped reads give zero
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= wb_hit;
         if (wb_hit && !WB_WE_I) WB_DAT_O <= rd_mux;
      end
   end

   // Address register, one byte lane per generate entry
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_addr_lane
         localparam int HI = (gi == 2) ? ADDR_W - 1 : gi * 8 + 7;
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) addr_q[HI:gi*8] <= '0;
            else if (wr_addr && WB_SEL_I[gi])
               addr_q[HI:gi*8] <= WB_DAT_I[HI:gi*8];
         end
      end
   endgenerate

   // Software registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         op_q <= OP_READ_ARRAY;
         wdata_q <= '0;
         {RESET_POWERDOWN_N, RP_OVERRIDE, VPP_ENABLE} <= PINCTL_RESET;
      end else begin
         if (start) op_q <= WB_DAT_I[OP_W-1:0];
         if (wr_wdata) wdata_q <= WB_DAT_I[DQ_W-1:0];
         if (wr_pin) begin
            VPP_ENABLE <= WB_DAT_I[PIN_VPP];
            RP_OVERRIDE <= WB_DAT_I[PIN_OVERRIDE];
            RESET_POWERDOWN_N <= WB_DAT_I[PIN_RUN];
         end
      end
   end

   // ************************************************************
   // Operation decode
   // ************************************************************
   wire op_erase = (op_q == OP_ERASE);
   wire op_prog = (op_q == OP_PROGRAM);
   wire op_susp = (op_q == OP_SUSPEND);
   wire op_res = (op_q == OP_RESUME);
   wire op_stat = (op_q == OP_READ_STATUS);
   wire op_plain = (op_q == OP_READ);
   wire has2 = op_erase | op_prog;
   wire has_rd = op_stat | op_plain | (op_q == OP_READ_ID);
   wire polls = has2 | op_susp | op_res;
   // First code of the order being started; identifier and status
   // commands go out whatever the supply levels
   wire [DQ_W-1:0] code1 =
      (new_op == OP_READ_ARRAY) ? CMD_READ_ARRAY :
      (new_op == OP_READ_ID) ? CMD_READ_ID : // see R27
      (new_op == OP_READ_STATUS) ? CMD_READ_STATUS : // see R3
      (new_op == OP_CLEAR_STATUS) ? CMD_CLEAR_STATUS :
      (new_op == OP_ERASE) ? CMD_ERASE_SETUP : // see R23
      (new_op == OP_PROGRAM) ? CMD_PROG_SETUP :
      (new_op == OP_SUSPEND) ? CMD_SUSPEND : CMD_CONFIRM; // see R24
   wire [DQ_W-1:0] code2 = op_erase ? CMD_CONFIRM : wdata_q; // see R8
   // Poll reads wait for the ready pin, status bit 7 decides the end
   wire poll_go = READY_BUSY_N; // see R9
   wire done_ready = cyc.rdata[SR_READY];

   assign cyc.req = req_q;
   assign cyc.wr = cwr_q;
   assign cyc.addr = addr_q; // see R8
   assign cyc.wdata = cdata_q;

   // ************************************************************
   // Sequencer
   // ************************************************************
   // A read is re-issued only after the engine has raised the strobes,
   // so each poll sees a freshly latched status byte
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= S_IDLE;
         req_q <= 1'b0;
         cwr_q <= 1'b0;
         cdata_q <= '0;
         fstat_q <= '0;
         rdata_q <= '0;
         suspended_q <= 1'b0;
      end else begin
         req_q <= 1'b0;
         case (state_q)
            S_IDLE: if (start) begin
               req_q <= 1'b1;
               if (WB_DAT_I[OP_W-1:0] == OP_READ) begin
                  cwr_q <= 1'b0;
                  state_q <= S_READ;
               end else begin
                  cwr_q <= 1'b1;
                  state_q <= S_CMD1;
               end
            end
            S_CMD1: if (cyc.done) begin
               if (has2) begin
                  req_q <= 1'b1;
                  cdata_q <= code2; // see R13
                  state_q <= S_CMD2;
               end else if (has_rd) begin
                  req_q <= 1'b1;
                  cwr_q <= 1'b0;
                  state_q <= S_READ;
               end else if (polls) begin
                  cwr_q <= 1'b0;
                  state_q <= S_POLL;
               end else begin
                  state_q <= S_IDLE;
               end
            end
            S_CMD2: if (cyc.done) begin
               cwr_q <= 1'b0;
               state_q <= S_POLL;
            end
            S_READ: if (cyc.done) begin
               rdata_q <= cyc.rdata;
               if (op_stat) fstat_q <= cyc.rdata; // see R4
               state_q <= S_IDLE;
            end
            S_POLL: begin
               if (!req_q && poll_go && !cyc.done && !busy_cyc)
                  req_q <= 1'b1;
               if (cyc.done) begin
                  fstat_q <= cyc.rdata; // see R6
                  if (done_ready) begin
                     state_q <= S_IDLE;
                     if (op_susp)
                        suspended_q <= cyc.rdata[SR_ERASE_SUSP]
                           | cyc.rdata[SR_PROG_SUSP]; // see R17 R20
                     else if (op_res)
                        suspended_q <= 1'b0; // see R21
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
         if (start) cdata_q <= code1;
         // Suspend order taken during a poll wait
         if (start && !idle) begin
            req_q <= 1'b1;
            cwr_q <= 1'b1;
            state_q <= S_CMD1;
         end
      end
   end

   // Engine occupancy, so a poll read is never requested twice
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) busy_cyc <= 1'b0;
      else if (req_q) busy_cyc <= 1'b1;
      else if (cyc.done) busy_cyc <= 1'b0;
   end

   // ************************************************************
   // Sub-blocks
   // ************************************************************
   fcs_tick u_tick (
      .clk(CLK),
      .rst_b(RST_B),
      .tick(tick)
   );

   fcs_pin_engine u_engine (
      .clk(CLK),
      .rst_b(RST_B),
      .tick(tick),
      .cyc(cyc.engine),
      .fl_dq_i(FL_DQ_I),
      .fl_addr(FL_ADDR),
      .fl_dq_o(FL_DQ_O),
      .fl_dq_oe(FL_DQ_OE),
      .fl_ce_b(FL_CE_B),
      .fl_oe_b(FL_OE_B),
      .fl_we_b(FL_WE_B)
   );

   // ************************************************************
   // Checks
   // ************************************************************
   chk_wb_ack_drop: assert property (@(posedge CLK) disable iff (!RST_B)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held for more than one cycle");

   chk_erase_confirm: assert property (@(posedge CLK) disable iff (!RST_B)
      (state_q == S_CMD2 && op_erase && req_q) |->
      (cdata_q == CMD_CONFIRM && FL_ADDR == addr_q)) // see R8
      else $error("erase confirm wrong code or address");

   chk_prog_setup: assert property (@(posedge CLK) disable iff (!RST_B)
      (state_q == S_CMD1 && op_prog && req_q) |->
      cdata_q == CMD_PROG_SETUP) // see R13
      else $error("byte write setup code wrong");

   chk_status_cmd: assert property (@(posedge CLK) disable iff (!RST_B)
      (state_q == S_CMD1 && op_stat && req_q) |->
      cwr_q && cdata_q == CMD_READ_STATUS) // see R25
      else $error("status command code wrong");

   chk_suspend_code: assert property (@(posedge CLK) disable iff (!RST_B)
      (state_q == S_CMD1 && op_susp && req_q) |->
      cdata_q == CMD_SUSPEND) // see R24
      else $error("suspend command code wrong");

   chk_supply_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (suspended_q && $past(suspended_q)) |->
      $stable(VPP_ENABLE) && $stable(RP_OVERRIDE)) // see R22
      else $error("supply or override moved while suspended");

   chk_poll_ends: assert property (@(posedge CLK) disable iff (!RST_B)
      (state_q == S_POLL && cyc.done && cyc.rdata[SR_READY]) |=>
      state_q == S_IDLE && fstat_q[SR_READY]) // see R9
      else $error("poll did not end on ready status");
endmodule // fcs_host

//--- fcs_pin_engine.sv
/*
 * Pin engine: turns one request into one asynchronous flash bus cycle
 * (address setup, chip enable with write or output enable, recovery).
 * Assumes requests arrive only while it is idle.
 */
`timescale 1ns/1ps
module fcs_pin_engine (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tick,
   fcs_cyc_if.engine cyc,
   input wire logic [fcs_pkg::DQ_W-1:0] fl_dq_i,
   output logic [fcs_pkg::ADDR_W-1:0] fl_addr,
   output logic [fcs_pkg::DQ_W-1:0] fl_dq_o,
   output logic fl_dq_oe,
   output logic fl_ce_b,
   output logic fl_oe_b,
   output logic fl_we_b
);
   import fcs_pkg::*;

   fcs_eng_state_t state_q;
   logic wr_q;
   logic [1:0] cnt_q;

   // ************************************************************
   // Cycle sequencing
   // ************************************************************
   // Data stays driven through recovery so the flash latches it on the
   // rising write enable with hold time to spare
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= E_IDLE;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
         fl_addr <= '0;
         fl_dq_o <= '0;
         fl_dq_oe <= 1'b0;
         fl_ce_b <= 1'b1;
         fl_oe_b <= 1'b1;
         fl_we_b <= 1'b1;
         cyc.rdata <= '0;
         cyc.done <= 1'b0;
      end else begin
         cyc.done <= 1'b0;
         case (state_q)
            E_IDLE: if (cyc.req) begin
               wr_q <= cyc.wr;
               fl_addr <= cyc.addr;
               fl_dq_o <= cyc.wdata;
               fl_dq_oe <= cyc.wr;
               state_q <= E_SETUP;
            end
            E_SETUP: if (tick) begin
               fl_ce_b <= 1'b0;
               fl_we_b <= ~wr_q; // see R13
               fl_oe_b <= wr_q;
               cnt_q <= STROBE_LAST;
               state_q <= E_STROBE;
            end
            E_STROBE: if (tick) begin
               if (cnt_q == 2'h0) begin
                  fl_ce_b <= 1'b1;
                  fl_oe_b <= 1'b1; // see R5
                  fl_we_b <= 1'b1;
                  if (!wr_q) cyc.rdata <= fl_dq_i;
                  state_q <= E_RECOV;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            E_RECOV: if (tick) begin
               fl_dq_oe <= 1'b0;
               cyc.done <= 1'b1;
               state_q <= E_IDLE;
            end
            default: state_q <= E_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   chk_strobe_excl: assert property (@(posedge clk) disable iff (!rst_b)
      !(!fl_oe_b && !fl_we_b)) // see R13
      else $error("output and write enable low together");

   chk_data_during_we: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(fl_we_b) |-> fl_dq_oe [*8]) // see R13
      else $error("data not driven while write enable low");

   chk_oe_high_between: assert property (@(posedge clk)
      disable iff (!rst_b)
      $rose(fl_oe_b) |-> fl_oe_b [*5]) // see R5
      else $error("output enable not held high between reads");
endmodule // fcs_pin_engine

//--- fcs_pkg.sv
/*
 * Shared constants and types of the flash command/status sequencer host:
 * register map, flash command codes, status bit positions, pin timing.
 * Assumes a 125 MHz clock and a byte-wide flash with a 20-bit address.
 */
package fcs_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 20;
   localparam int DQ_W = 8;
   localparam int WB_AW = 8;
   localparam int OP_W = 4;

   // ************************************************************
   // Software register map, byte addresses
   // ************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_PINCTL = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;

   // Control-pin register fields and reset value
   localparam int PIN_VPP = 0;
   localparam int PIN_OVERRIDE = 1;
   localparam int PIN_RUN = 2;
   localparam logic [2:0] PINCTL_RESET = 3'h4;

   // Status register fields
   localparam int ST_BUSY = 0;
   localparam int ST_SUSP = 1;
   localparam int ST_FSTAT_LSB = 8;
   localparam int ST_RDATA_LSB = 16;

   // ************************************************************
   // Operations that software orders through the control register
   // ************************************************************
   localparam logic [3:0] OP_READ_ARRAY = 4'h0;
   localparam logic [3:0] OP_READ_ID = 4'h1;
   localparam logic [3:0] OP_READ_STATUS = 4'h2;
   localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
   localparam logic [3:0] OP_ERASE = 4'h4;
   localparam logic [3:0] OP_PROGRAM = 4'h5;
   localparam logic [3:0] OP_SUSPEND = 4'h6;
   localparam logic [3:0] OP_RESUME = 4'h7;
   localparam logic [3:0] OP_READ = 4'h8;

   // ************************************************************
   // Flash command codes
   // ************************************************************
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
   localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;

   // Identifier-mode locations (low address bits)
   localparam logic [19:0] ID_MAKER = 20'h0_0000;
   localparam logic [19:0] ID_PART = 20'h0_0001;
   localparam logic [19:0] ID_BLOCK_PROT = 20'h0_0002;
   localparam logic [19:0] ID_GLOBAL_PROT = 20'h0_0003;

   // Flash status bits
   localparam int SR_READY = 7;
   localparam int SR_ERASE_SUSP = 6;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_SUPPLY_LOW = 3;
   localparam int SR_PROG_SUSP = 2;
   localparam int SR_PROTECT = 1;

   // ************************************************************
   // Pin timing: one tick sets up, strobes span ticks, one recovers
   // ************************************************************
   localparam int CLK_NS = 8;
   localparam int TICK_NS = 40;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);
   localparam int STROBE_NS = 120;
   localparam int STROBE_TICKS = (STROBE_NS + TICK_NS - 1) / TICK_NS;
   localparam logic [1:0] STROBE_LAST = 2'(STROBE_TICKS - 1);

   typedef enum logic [3:0] {
      E_IDLE = 4'b0001,
      E_SETUP = 4'b0010,
      E_STROBE = 4'b0100,
      E_RECOV = 4'b1000
   } fcs_eng_state_t;

   typedef enum logic [4:0] {
      S_IDLE = 5'b0_0001,
      S_CMD1 = 5'b0_0010,
      S_CMD2 = 5'b0_0100,
      S_READ = 5'b0_1000,
      S_POLL = 5'b1_0000
   } fcs_seq_state_t;

endpackage

//--- fcs_tick.sv
/*
 * Divider giving a one-cycle enable pulse every TICK_CYC clocks.
 * Assumes the pin engine paces all strobe phases from this pulse.
 */
`timescale 1ns/1ps
module fcs_tick (
   input wire logic clk,
   input wire logic rst_b,
   output logic tick
);
   import fcs_pkg::*;

   logic [2:0] cnt_q;

   // Free-running count, pulse on wrap
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 3'h0;
         tick <= 1'b0;
      end else begin
         cnt_q <= (cnt_q == TICK_LAST) ? 3'h0 : cnt_q + 3'h1;
         tick <= (cnt_q == TICK_LAST);
      end
   end
endmodule // fcs_tick

//--- testbench.sv
/* Self-checking bench for fcs_host with the flash model on its pins.
   Assumes the bench resolves the data bus from FL_DQ_OE. */
`timescale 1ns/1ps
module testbench;
   import fcs_pkg::*;
   logic CLK = 0, RST_B = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0, dq_o, m_dq;
   logic [31:0] wd = 0, rdat = 0, dat;
   logic ack, dq_oe, ce, oe, wr, rdy, ovr, vpp;
   logic [19:0] fa;
   logic [19:0] ida [5] = '{20'h0, 20'h1, 20'h1_0002, 20'h2, 20'h3};
   logic [7:0] ids [5] = '{8'h5C, 8'h3E, 8'h01, 8'h00, 8'h00};
   wire [7:0] dq = dq_oe ? dq_o : m_dq;
   int num_errors = 0, compares = 0;
   initial forever #4 CLK = ~CLK;
   fcs_host fcs_host_inst (.CLK(CLK), .RST_B(RST_B), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
      .WB_DAT_I(wd), .WB_DAT_O(dat), .WB_ACK_O(ack), .FL_DQ_I(dq),
      .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_ADDR(fa), .FL_CE_B(ce),
      .FL_OE_B(oe), .FL_WE_B(wr), .READY_BUSY_N(rdy),
      .RESET_POWERDOWN_N(), .RP_OVERRIDE(ovr), .VPP_ENABLE(vpp));
   fcs_flash_model fcs_flash_model_inst (.clk(CLK), .addr(fa), .din(dq),
      .oe_b(oe), .we_b(wr), .ce_b(ce), .vpp(vpp), .ovr(ovr),
      .dout(m_dq), .rdy(rdy));
   task automatic results();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // A wait that ran out ends the run as a failure
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         num_errors++;
         results();
      end
   endtask
   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge CLK);
         n++;
      end while (ack !== 1'b1 && n < 50);
      guard(n, 50);
      rdat = dat;
      cyc <= 0;
      stb <= 0;
   endtask
   // Orders one operation, then polls until the host is idle
   task automatic run(input logic [3:0] op, input logic [19:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      wb(1, OFF_ADDR, {12'h0, a});
      wb(1, OFF_WDATA, {24'h0, d});
      wb(1, OFF_CTRL, {28'h0, op});
      do begin
         wb(0, OFF_STAT, 0);
         n++;
      end while (rdat[ST_BUSY] !== 1'b0 && n < 500);
      guard(n, 500);
   endtask
   // Runs an operation and checks read data (r=1) or flash status
   task automatic step(input logic [3:0] op, input logic [19:0] a,
      input logic [7:0] d, input logic r, input logic [7:0] e);
      run(op, a, d);
      chk(r ? rdat[23:16] : rdat[15:8], e);
   endtask
   // Back to array reads, then one plain read checked against e
   task automatic arr(input logic [19:0] a, input logic [7:0] e);
      run(OP_READ_ARRAY, 0, 0);
      step(OP_READ, a, 0, 1, e);
   endtask
   initial begin
      repeat (20) @(posedge CLK);
      RST_B <= 1;
      wb(0, 8'h40, 0);
      chk(rdat[7:0], 8'h00);
      wb(0, OFF_PINCTL, 0);
      chk(rdat[7:0], {5'h0, PINCTL_RESET});
      foreach (ida[i]) step(OP_READ_ID, ida[i], 0, 1, ids[i]);
      step(OP_PROGRAM, 20'h5, 8'h5A, 0, 8'h98);
      step(OP_ERASE, 20'h5, 0, 0, 8'hB8);
      run(OP_CLEAR_STATUS, 0, 0);
      step(OP_READ_STATUS, 0, 0, 0, 8'h80);
      wb(1, OFF_PINCTL, 32'h5);
      step(OP_PROGRAM, 20'h5, 8'h5A, 0, 8'h80);
      arr(20'h5, 8'h5A);
      step(OP_PROGRAM, 20'h5, 8'hA5, 0, 8'h80);
      arr(20'h5, 8'h00);
      step(OP_PROGRAM, 20'h1_0005, 0, 0, 8'h92);
      step(OP_ERASE, 20'h1_0000, 0, 0, 8'hB2);
      run(OP_CLEAR_STATUS, 0, 0);
      step(OP_ERASE, 20'h0_0003, 0, 0, 8'h80);
      arr(20'h5, 8'hFF);
      wb(1, OFF_PINCTL, 32'h7);
      step(OP_PROGRAM, 20'h1_0005, 8'h3C, 0, 8'h80);
      arr(20'h1_0005, 8'h3C);
      wb(1, OFF_ADDR, 32'h3);
      wb(1, OFF_CTRL, {28'h0, OP_ERASE});
      repeat (60) @(posedge CLK);
      step(OP_SUSPEND, 0, 0, 0, 8'hC0);
      chk(rdat[7:0], 8'h02);
      step(OP_RESUME, 0, 0, 0, 8'h80);
      chk(rdat[7:0], 8'h00);
      results();
   end
endmodule // testbench
